//--- design/uic_pkg.sv
// Constants, source encodings and carriers for the UART interrupt and FIFO control block.
// Assumes a host register port with a 3-bit address, same-clock read and write strobes.
package uic_pkg;
   // Register addresses on the 3-bit host port
   localparam logic [2:0] ADDR_HOLD = 3'h0;
   localparam logic [2:0] ADDR_MASK = 3'h1;
   localparam logic [2:0] ADDR_SRC = 3'h2;
   localparam logic [2:0] ADDR_LINE = 3'h5;
   localparam logic [2:0] ADDR_MODEM = 3'h6;

   // Reset values
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] QCTL_RST = 8'h00;

   // Mask register bit positions
   localparam int MSK_RX = 0;
   localparam int MSK_TX = 1;
   localparam int MSK_LINE = 2;
   localparam int MSK_MODEM = 3;
   localparam int MSK_SLEEP = 4;
   localparam int MSK_XOFF = 5;
   localparam int MSK_RTS = 6;
   localparam int MSK_CTS = 7;
   localparam logic [7:0] MSK_ENH_FIELD = 8'hF0;

   // Queue control bit positions
   localparam int QC_EN = 0;
   localparam int QC_RXRST = 1;
   localparam int QC_TXRST = 2;
   localparam int QC_WAKE = 3;
   localparam int QC_TXTRIG_LO = 4;
   localparam int QC_RXTRIG_LO = 6;
   localparam logic [7:0] QC_ENH_FIELD = 8'h38;

   // Interrupt source codes, bits 5:0
   localparam logic [5:0] CODE_LINE = 6'h06;
   localparam logic [5:0] CODE_TMO = 6'h0C;
   localparam logic [5:0] CODE_RXR = 6'h04;
   localparam logic [5:0] CODE_TXR = 6'h02;
   localparam logic [5:0] CODE_MODEM = 6'h00;
   localparam logic [5:0] CODE_FLOW = 6'h10;
   localparam logic [5:0] CODE_PIN = 6'h20;
   localparam logic [5:0] CODE_NONE = 6'h01;

   // Receive timeout: character times plus extra bit times
   localparam logic [6:0] TMO_CHARS = 7'h04;
   localparam logic [6:0] TMO_EXTRA_BITS = 7'h0C;

   // Presented interrupt source, one-hot
   typedef enum logic [8:0] {
      SRC_NONE = 9'h001,
      SRC_LINE = 9'h002,
      SRC_TMO = 9'h004,
      SRC_RXR = 9'h008,
      SRC_TXR = 9'h010,
      SRC_MODEM = 9'h020,
      SRC_FLOW = 9'h040,
      SRC_PIN = 9'h080,
      SRC_WAKE = 9'h100
   } uic_src_e;

   // Receive path status from the receiver and RX FIFO
   typedef struct packed {
      logic push;
      logic overrun;
      logic err_on_push;
      logic [2:0] err_top;
      logic err_in_fifo;
      logic [6:0] count;
   } uic_rx_s;

   // Flow control and power events
   typedef struct packed {
      logic xon_det;
      logic xoff_det;
      logic special_det;
      logic wake;
   } uic_evt_s;
endpackage

//--- design/uic_ctrl.sv
// Interrupt masking, prioritised source reporting and queue control of a UART with 64-byte FIFOs.
// Assumes all strobes and status inputs come from logic on ref_clk_i; only cts_n_i is a pin.
//
// Overview of operation
// - FIFO mode: receive-ready interrupt while RX fill is at or above trigger.
// - Data-ready status set when a character enters; cleared when RX empties.
// - Line status reports overrun, top-byte errors, transmit empties, errored character present.
// - Receive interrupt: holding full in non-FIFO mode, trigger reached in FIFO mode.
// - Transmit interrupt on holding empty or below trigger; immediate if enabled while empty.
// - Overrun interrupts at once; other errors at holding or entry by mode bit.
// - Mask bits 7:4 act only with enhanced enable; all mask bits reset zero.
// - Interrupt on low-to-high of handshake input or output during auto flow control.
// - Source register presents one pending source, held until that one is serviced.
// - Timeout after four characters plus 12 bits; transmit from trigger or empty.
// - Wakeup interrupt on leaving sleep if enabled; flow character interrupt on detection.
// - Line status, holding, modem status reads clear their interrupts; receive clears below trigger.
// - Transmit clears on source read or holding write; flow and wake on source read.
// - Source bits 5:0 encode the seven priorities; 000001 means none or wakeup.
// - Source bit 0 low while a source other than wakeup is presented, high when none or wakeup, high after reset.
// - Source bits 5:4 only with enhanced enable; bits 7:6 show FIFO enable.
// - Queue control bit 0 enables FIFOs; other bits taken only with bit 0 set.
// - RX/TX reset bits clear FIFO pointers and levels, then self-clear.
// - Transmit trigger select bits 5:4 need enhanced enable; interrupt below trigger or empty.
// - Bits 7:6 select receive trigger; bit 3 enables wakeup with enhanced enable.
// - One trigger table serves both directions; the latest selection applies.
// - Enhanced mask, source and queue control bits writable only with enhanced enable.
`timescale 1ns/10ps
module uic_ctrl (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [2:0] addr_i,
   input wire logic rd_stb_i,
   input wire logic wr_stb_i,
   input wire logic [7:0] wdata_i,
   input wire logic divisor_sel_i,
   input wire logic enh_bank_i,
   input wire logic enh_en_i,
   input wire logic auto_rts_en_i,
   input wire logic auto_cts_en_i,
   input wire logic err_at_entry_i,
   input wire uic_pkg::uic_rx_s rx_i,
   input wire logic [6:0] tx_count_i,
   input wire logic tx_shifter_empty_i,
   input wire logic [6:0] rx_trig_i,
   input wire logic [6:0] tx_trig_i,
   input wire logic bit_tick_i,
   input wire logic [3:0] char_bits_i,
   input wire logic [3:0] modem_delta_i,
   input wire logic [7:0] modem_status_i,
   input wire uic_pkg::uic_evt_s evt_i,
   input wire logic cts_n_i,
   input wire logic rts_n_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic fifo_en_o,
   output logic rx_fifo_rst_o,
   output logic tx_fifo_rst_o,
   output logic [1:0] rx_trig_sel_o,
   output logic [1:0] tx_trig_sel_o,
   output logic sleep_en_o,
   output logic rx_pop_o,
   output logic tx_push_o
);
   logic [7:0] mask_ff;
   logic [7:0] qctl_ff;
   logic overrun_ff;
   logic line_ff;
   logic tmo_ff;
   logic txr_ff;
   logic flow_ff;
   logic spec_ff;
   logic pin_ff;
   logic wake_ff;
   logic [6:0] tmo_cnt_ff;
   logic [6:0] tx_prev_ff;
   logic tx_over_ff;
   logic [2:0] err_top_prev_ff;
   logic cts_meta_ff;
   logic cts_sync_ff;
   logic cts_prev_ff;
   logic rts_prev_ff;
   uic_pkg::uic_src_e src_ff;
   uic_pkg::uic_src_e nxt_src;
   logic [5:0] code;
   logic [7:0] nxt_rdata;
   logic [7:0] mask_eff;
   logic hold_rd;
   logic hold_wr;
   logic mask_wr;
   logic src_rd;
   logic qctl_wr;
   logic line_rd;
   logic modem_rd;
   logic fifo_on;
   logic rx_ready;
   logic [6:0] tmo_limit;
   logic tx_set;
   logic line_set;
   logic p_line, p_tmo, p_rxr, p_txr, p_modem, p_flow, p_pin, p_wake;
   logic still;

   assign hold_rd = rd_stb_i && addr_i == uic_pkg::ADDR_HOLD && !divisor_sel_i;
   assign hold_wr = wr_stb_i && addr_i == uic_pkg::ADDR_HOLD && !divisor_sel_i;
   assign mask_wr = wr_stb_i && addr_i == uic_pkg::ADDR_MASK && !divisor_sel_i;
   assign src_rd = rd_stb_i && addr_i == uic_pkg::ADDR_SRC && !enh_bank_i;
   assign qctl_wr = wr_stb_i && addr_i == uic_pkg::ADDR_SRC && !enh_bank_i;
   assign line_rd = rd_stb_i && addr_i == uic_pkg::ADDR_LINE;
   assign modem_rd = rd_stb_i && addr_i == uic_pkg::ADDR_MODEM;
   assign fifo_on = qctl_ff[uic_pkg::QC_EN];
   // Upper mask bits count only while enhanced enable is set
   assign mask_eff = enh_en_i ? mask_ff : (mask_ff & ~uic_pkg::MSK_ENH_FIELD);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mask_ff <= uic_pkg::MASK_RST;
      end else if (mask_wr) begin
         mask_ff <= enh_en_i ? wdata_i
                             : {mask_ff[7:4], wdata_i[3:0]};
      end
   end

   // Queue control: bit 0 always taken, the rest only alongside bit 0
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         qctl_ff <= uic_pkg::QCTL_RST;
      end else if (qctl_wr) begin
         if (!wdata_i[uic_pkg::QC_EN]) begin
            qctl_ff[uic_pkg::QC_EN] <= 1'b0;
         end else begin
            qctl_ff[uic_pkg::QC_EN] <= 1'b1;
            qctl_ff[7:6] <= wdata_i[7:6];
            if (enh_en_i) begin
               qctl_ff[5:3] <= wdata_i[5:3];
            end
         end
      end
   end

   // Reset requests are one-cycle pulses; the stored copy never holds them
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rx_fifo_rst_o <= 1'b0;
         tx_fifo_rst_o <= 1'b0;
      end else begin
         rx_fifo_rst_o <= qctl_wr && wdata_i[uic_pkg::QC_EN] && wdata_i[uic_pkg::QC_RXRST];
         tx_fifo_rst_o <= qctl_wr && wdata_i[uic_pkg::QC_EN] && wdata_i[uic_pkg::QC_TXRST];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         fifo_en_o <= 1'b0;
         rx_trig_sel_o <= 2'h0;
         tx_trig_sel_o <= 2'h0;
         sleep_en_o <= 1'b0;
         rx_pop_o <= 1'b0;
         tx_push_o <= 1'b0;
      end else begin
         fifo_en_o <= fifo_on;
         rx_trig_sel_o <= qctl_ff[7:6];
         tx_trig_sel_o <= qctl_ff[5:4];
         sleep_en_o <= mask_eff[uic_pkg::MSK_SLEEP];
         rx_pop_o <= hold_rd;
         tx_push_o <= hold_wr;
      end
   end

   // Handshake pin: two flops before any edge logic
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cts_meta_ff <= 1'b0;
         cts_sync_ff <= 1'b0;
         cts_prev_ff <= 1'b0;
         rts_prev_ff <= 1'b0;
      end else begin
         cts_meta_ff <= cts_n_i;
         cts_sync_ff <= cts_meta_ff;
         cts_prev_ff <= cts_sync_ff;
         rts_prev_ff <= rts_n_i;
      end
   end

   // Receive ready follows the fill level, so draining clears it with no flag
   assign rx_ready = fifo_on ? (rx_i.count >= rx_trig_i) : (rx_i.count != 7'h00);

   // Line status: overrun at once, errors at holding or at entry
   assign line_set = rx_i.overrun
                  || (err_at_entry_i ? rx_i.err_on_push
                                     : (|(rx_i.err_top & ~err_top_prev_ff)));

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         overrun_ff <= 1'b0;
         line_ff <= 1'b0;
         err_top_prev_ff <= 3'h0;
      end else begin
         err_top_prev_ff <= rx_i.err_top;
         // A new event in the clearing read cycle survives
         if (rx_i.overrun) begin
            overrun_ff <= 1'b1;
         end else if (line_rd) begin
            overrun_ff <= 1'b0;
         end
         if (line_set) begin
            line_ff <= 1'b1;
         end else if (line_rd) begin
            line_ff <= 1'b0;
         end
      end
   end

   // Timeout: restarted by any receive activity, counted in bit times
   assign tmo_limit = 7'(uic_pkg::TMO_CHARS * {3'h0, char_bits_i}) + uic_pkg::TMO_EXTRA_BITS;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         tmo_cnt_ff <= 7'h00;
         tmo_ff <= 1'b0;
      end else begin
         if (rx_i.push || hold_rd || rx_i.count == 7'h00 || !fifo_on) begin
            tmo_cnt_ff <= 7'h00;
         end else if (bit_tick_i && tmo_cnt_ff != tmo_limit) begin
            tmo_cnt_ff <= tmo_cnt_ff + 7'h01;
         end
         if (fifo_on && bit_tick_i && tmo_cnt_ff == tmo_limit - 7'h01 && !rx_i.push) begin
            tmo_ff <= 1'b1;
         end else if (hold_rd) begin
            tmo_ff <= 1'b0;
         end
      end
   end

   // Transmit ready: falling below trigger, or draining empty after a shallow reload
   assign tx_set = fifo_on
                 ? ((tx_prev_ff >= tx_trig_i && tx_count_i < tx_trig_i)
                    || (tx_prev_ff != 7'h00 && tx_count_i == 7'h00 && !tx_over_ff))
                 : (tx_prev_ff != 7'h00 && tx_count_i == 7'h00);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         tx_prev_ff <= 7'h00;
         tx_over_ff <= 1'b0;
         txr_ff <= 1'b0;
      end else begin
         tx_prev_ff <= tx_count_i;
         if (tx_count_i > tx_trig_i) begin
            tx_over_ff <= 1'b1;
         end else if (tx_count_i == 7'h00) begin
            tx_over_ff <= 1'b0;
         end
         if ((tx_set && mask_ff[uic_pkg::MSK_TX])
             || (mask_wr && wdata_i[uic_pkg::MSK_TX] && !mask_ff[uic_pkg::MSK_TX]
                 && tx_count_i == 7'h00)) begin
            txr_ff <= 1'b1;
         end else if (hold_wr || (src_rd && src_ff == uic_pkg::SRC_TXR)) begin
            txr_ff <= 1'b0;
         end
      end
   end

   // Flow character, special character, pin change and wakeup flags
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         flow_ff <= 1'b0;
         spec_ff <= 1'b0;
         pin_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         if (evt_i.xon_det || evt_i.xoff_det) begin
            flow_ff <= 1'b1;
         end else if (src_rd && src_ff == uic_pkg::SRC_FLOW) begin
            flow_ff <= 1'b0;
         end
         if (evt_i.special_det) begin
            spec_ff <= 1'b1;
         end else if ((src_rd && src_ff == uic_pkg::SRC_FLOW) || rx_i.push) begin
            spec_ff <= 1'b0;
         end
         if ((auto_cts_en_i && mask_eff[uic_pkg::MSK_CTS] && cts_sync_ff && !cts_prev_ff)
             || (auto_rts_en_i && mask_eff[uic_pkg::MSK_RTS] && rts_n_i && !rts_prev_ff)) begin
            pin_ff <= 1'b1;
         end else if (modem_rd) begin
            pin_ff <= 1'b0;
         end
         if (evt_i.wake && enh_en_i && qctl_ff[uic_pkg::QC_WAKE]) begin
            wake_ff <= 1'b1;
         end else if (src_rd && src_ff == uic_pkg::SRC_WAKE) begin
            wake_ff <= 1'b0;
         end
      end
   end

   // Enabled pending conditions
   assign p_line = mask_eff[uic_pkg::MSK_LINE] && line_ff;
   assign p_tmo = mask_eff[uic_pkg::MSK_RX] && tmo_ff;
   assign p_rxr = mask_eff[uic_pkg::MSK_RX] && rx_ready;
   assign p_txr = mask_eff[uic_pkg::MSK_TX] && txr_ff;
   assign p_modem = mask_eff[uic_pkg::MSK_MODEM] && (|modem_delta_i);
   assign p_flow = enh_en_i && mask_eff[uic_pkg::MSK_XOFF] && (flow_ff || spec_ff);
   assign p_pin = enh_en_i && pin_ff;
   assign p_wake = wake_ff;

   // The presented source stays until its own condition is gone
   always_comb begin
      case (src_ff)
         uic_pkg::SRC_LINE: still = p_line;
         uic_pkg::SRC_TMO: still = p_tmo;
         uic_pkg::SRC_RXR: still = p_rxr;
         uic_pkg::SRC_TXR: still = p_txr;
         uic_pkg::SRC_MODEM: still = p_modem;
         uic_pkg::SRC_FLOW: still = p_flow;
         uic_pkg::SRC_PIN: still = p_pin;
         uic_pkg::SRC_WAKE: still = p_wake;
         default: still = 1'b0;
      endcase
      if (still) begin
         nxt_src = src_ff;
      end else if (p_line) begin
         nxt_src = uic_pkg::SRC_LINE;
      end else if (p_tmo) begin
         nxt_src = uic_pkg::SRC_TMO;
      end else if (p_rxr) begin
         nxt_src = uic_pkg::SRC_RXR;
      end else if (p_txr) begin
         nxt_src = uic_pkg::SRC_TXR;
      end else if (p_modem) begin
         nxt_src = uic_pkg::SRC_MODEM;
      end else if (p_flow) begin
         nxt_src = uic_pkg::SRC_FLOW;
      end else if (p_pin) begin
         nxt_src = uic_pkg::SRC_PIN;
      end else if (p_wake) begin
         nxt_src = uic_pkg::SRC_WAKE;
      end else begin
         nxt_src = uic_pkg::SRC_NONE;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         src_ff <= uic_pkg::SRC_NONE;
      end else begin
         src_ff <= nxt_src;
      end
   end

   always_comb begin
      case (src_ff)
         uic_pkg::SRC_LINE: code = uic_pkg::CODE_LINE;
         uic_pkg::SRC_TMO: code = uic_pkg::CODE_TMO;
         uic_pkg::SRC_RXR: code = uic_pkg::CODE_RXR;
         uic_pkg::SRC_TXR: code = uic_pkg::CODE_TXR;
         uic_pkg::SRC_MODEM: code = uic_pkg::CODE_MODEM;
         uic_pkg::SRC_FLOW: code = uic_pkg::CODE_FLOW;
         uic_pkg::SRC_PIN: code = uic_pkg::CODE_PIN;
         default: code = uic_pkg::CODE_NONE;
      endcase
   end

   // Read data is registered; unmapped addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      if (rd_stb_i) begin
         case (addr_i)
            uic_pkg::ADDR_MASK: nxt_rdata = divisor_sel_i ? 8'h00 : mask_ff;
            uic_pkg::ADDR_SRC: nxt_rdata = enh_bank_i ? 8'h00 : {fifo_on, fifo_on, code};
            uic_pkg::ADDR_LINE: nxt_rdata = {rx_i.err_in_fifo,
                                             tx_count_i == 7'h00 && tx_shifter_empty_i,
                                             tx_count_i == 7'h00,
                                             rx_i.err_top,
                                             overrun_ff,
                                             rx_i.count != 7'h00};
            uic_pkg::ADDR_MODEM: nxt_rdata = modem_status_i;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         rdata_o <= nxt_rdata;
         irq_o <= p_line || p_tmo || p_rxr || p_txr || p_modem || p_flow || p_pin || p_wake;
      end
   end
endmodule

//--- verif/uic_ctrl_sva.sv
// Checker for the interrupt and queue control block, bound to its ports.
// Assumes single-cycle host strobes on ref_clk_i.
`timescale 1ns/10ps
module uic_ctrl_sva (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [2:0] addr_i,
   input wire logic rd_stb_i,
   input wire logic wr_stb_i,
   input wire logic [7:0] wdata_i,
   input wire logic divisor_sel_i,
   input wire logic enh_bank_i,
   input wire logic enh_en_i,
   input wire uic_pkg::uic_rx_s rx_i,
   input wire logic [6:0] rx_trig_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic fifo_en_o,
   input wire logic rx_fifo_rst_o,
   input wire logic tx_fifo_rst_o,
   input wire logic [1:0] rx_trig_sel_o,
   input wire logic rx_pop_o,
   input wire logic tx_push_o
);
   logic [7:0] msk_ff;
   wire logic qc_wr = wr_stb_i && addr_i == uic_pkg::ADDR_SRC && !enh_bank_i;
   wire logic rx_rst_req = qc_wr && wdata_i[0] && wdata_i[1];
   default clocking cb_def @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);
   // Shadow of the mask so the receive interrupt can be tied to its enable
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         msk_ff <= uic_pkg::MASK_RST;
      end else if (wr_stb_i && addr_i == uic_pkg::ADDR_MASK && !divisor_sel_i) begin
         msk_ff <= enh_en_i ? wdata_i : {msk_ff[7:4], wdata_i[3:0]};
      end
   end
   sequence src_rd_s;
      rd_stb_i && !wr_stb_i && addr_i == uic_pkg::ADDR_SRC && !enh_bank_i;
   endsequence
   sequence hold_rd_s;
      rd_stb_i && addr_i == uic_pkg::ADDR_HOLD && !divisor_sel_i;
   endsequence
   src_fifo_bits_a: assert property (src_rd_s |=> rdata_o[7:6] == {2{$past(fifo_en_o)}})
      else $error("source bits 7:6 differ from FIFO enable");
   fen_write_a: assert property (qc_wr |=> ##1 fifo_en_o == $past(wdata_i[0], 2))
      else $error("FIFO enable does not follow write");
   rx_reset_a: assert property (rx_fifo_rst_o |-> $past(rx_rst_req))
      else $error("receive FIFO reset without request");
   tx_reset_a: assert property (qc_wr && wdata_i[0] && wdata_i[2] |=> tx_fifo_rst_o)
      else $error("transmit FIFO reset missing");
   trig_sel_a: assert property (qc_wr && wdata_i[0] |=> ##1 rx_trig_sel_o == $past(wdata_i[7:6], 2))
      else $error("receive trigger select not taken");
   mask_read_a: assert property (rd_stb_i && !wr_stb_i && addr_i == uic_pkg::ADDR_MASK && !divisor_sel_i
      |=> rdata_o == $past(msk_ff)) else $error("mask read value wrong");
   rx_irq_a: assert property (fifo_en_o && msk_ff[0] && rx_i.count >= rx_trig_i |=> irq_o)
      else $error("receive trigger reached without interrupt");
   hold_pop_a: assert property (hold_rd_s |=> rx_pop_o)
      else $error("holding read gave no pop");
   hold_push_a: assert property (wr_stb_i && addr_i == uic_pkg::ADDR_HOLD && !divisor_sel_i |=> tx_push_o)
      else $error("holding write gave no push");
   reset_quiet_a: assert property ($fell(srst_i) |-> !irq_o && !fifo_en_o)
      else $error("outputs active after reset");
endmodule
bind uic_ctrl uic_ctrl_sva i_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .rd_stb_i(rd_stb_i),
   .wr_stb_i(wr_stb_i), .wdata_i(wdata_i), .divisor_sel_i(divisor_sel_i), .enh_bank_i(enh_bank_i),
   .enh_en_i(enh_en_i), .rx_i(rx_i), .rx_trig_i(rx_trig_i), .rdata_o(rdata_o), .irq_o(irq_o),
   .fifo_en_o(fifo_en_o), .rx_fifo_rst_o(rx_fifo_rst_o), .tx_fifo_rst_o(tx_fifo_rst_o),
   .rx_trig_sel_o(rx_trig_sel_o), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o));

//--- verif/uic_host.sv
// Host model: one register access per call on the strobe port.
// Assumes the device takes a strobe on the rising edge and answers a cycle later.
`timescale 1ns/10ps
module uic_host (
   input wire logic ref_clk_i,
   input wire logic [7:0] rdata_i,
   output logic [2:0] addr_o,
   output logic rd_stb_o,
   output logic wr_stb_o,
   output logic [7:0] wdata_o
);
   initial begin
      addr_o = 3'h0;
      rd_stb_o = 1'b0;
      wr_stb_o = 1'b0;
      wdata_o = 8'h00;
   end
   // Strobe lasts one cycle; a longer one would repeat side effects
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      wdata_o = d;
      wr_stb_o = 1'b1;
      @(negedge ref_clk_i);
      wr_stb_o = 1'b0;
      wdata_o = ~d;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      addr_o = a;
      rd_stb_o = 1'b1;
      @(negedge ref_clk_i);
      d = rdata_i;
      rd_stb_o = 1'b0;
   endtask
endmodule

//--- verif/uart_interrupt_and_fifo_control_test.sv
// Bench for the interrupt and queue control block.
// Host model drives the register port; status inputs change at the falling edge.
`timescale 1ns/10ps
module uart_interrupt_and_fifo_control_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] addr;
   logic rd, wr, irq, fen, rxr, txr, slp, pop, push;
   logic [7:0] wdata, rdata, ms, d;
   logic [1:0] rxs, txs;
   logic enh = 1'b0, afc = 1'b0, rts_n = 1'b0, cts_n = 1'b0, sh_empty = 1'b1, tick = 1'b0;
   logic [6:0] tx_count = 7'h00, rx_trig = 7'h04;
   logic [3:0] delta = 4'h0;
   logic [31:0] seed = 32'h00006007;
   uic_pkg::uic_rx_s rx = '0;
   uic_pkg::uic_evt_s evt = '0;
   int fails = 0, total_checks = 0, rxr_n = 0, txr_n = 0;
   logic [7:0] msk_tab [8] = '{8'h04, 8'h01, 8'h02, 8'h08, 8'h20, 8'h80, 8'h40, 8'h00};
   logic [5:0] code_tab [8] = '{uic_pkg::CODE_LINE, uic_pkg::CODE_RXR, uic_pkg::CODE_TXR,
      uic_pkg::CODE_MODEM, uic_pkg::CODE_FLOW, uic_pkg::CODE_PIN, uic_pkg::CODE_PIN, uic_pkg::CODE_NONE};
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (rxr) rxr_n++;
      if (txr) txr_n++;
   end
   uic_host i_host (.ref_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .rd_stb_o(rd), .wr_stb_o(wr), .wdata_o(wdata));
   uic_ctrl i_dut (.ref_clk_i(clk), .srst_i(srst), .addr_i(addr), .rd_stb_i(rd), .wr_stb_i(wr), .wdata_i(wdata),
      .divisor_sel_i(1'b0), .enh_bank_i(1'b0), .enh_en_i(enh), .auto_rts_en_i(afc), .auto_cts_en_i(afc),
      .err_at_entry_i(1'b0), .rx_i(rx), .tx_count_i(tx_count), .tx_shifter_empty_i(sh_empty), .rx_trig_i(rx_trig),
      .tx_trig_i(7'h04), .bit_tick_i(tick), .char_bits_i(4'hA), .modem_delta_i(delta), .modem_status_i(ms),
      .evt_i(evt), .cts_n_i(cts_n), .rts_n_i(rts_n), .rdata_o(rdata), .irq_o(irq), .fifo_en_o(fen),
      .rx_fifo_rst_o(rxr), .tx_fifo_rst_o(txr), .rx_trig_sel_o(rxs), .tx_trig_sel_o(txs), .sleep_en_o(slp),
      .rx_pop_o(pop), .tx_push_o(push));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      i_host.rd_reg(a, v);
      chk(nm, e, v);
   endtask
   // Bounded wait: a hang ends the run with the report
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 8) begin
         @(negedge clk);
         n++;
      end
      chk("irq", {7'h00, v}, {7'h00, irq});
      if (irq !== v) give_verdict();
   endtask
   initial begin
      logic [31:0] r;
      r = rnd();
      ms = r[7:0];
      repeat (16) @(negedge clk);
      srst = 1'b0;
      rd_chk("source", uic_pkg::ADDR_SRC, 8'h01);
      rd_chk("mask", uic_pkg::ADDR_MASK, 8'h00);
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'hF0);
      rd_chk("mask", uic_pkg::ADDR_MASK, 8'h00);
      enh = 1'b1;
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'hF0);
      rd_chk("mask", uic_pkg::ADDR_MASK, 8'hF0);
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'h00);
      i_host.wr_reg(uic_pkg::ADDR_SRC, 8'h06);
      @(negedge clk);
      chk("fifo_en", 8'h00, {7'h00, fen});
      chk("fifo_rst", 8'h00, 8'(rxr_n + txr_n));
      i_host.wr_reg(uic_pkg::ADDR_SRC, 8'hF7);
      @(negedge clk);
      chk("fifo_rst", 8'h11, {4'(rxr_n), 4'(txr_n)});
      chk("trig_sel", 8'h0F, {4'h0, rxs, txs});
      enh = 1'b0;
      i_host.wr_reg(uic_pkg::ADDR_SRC, 8'h81);
      @(negedge clk);
      chk("trig_sel", 8'h0B, {4'h0, rxs, txs});
      enh = 1'b1;
      afc = 1'b1;
      i_host.wr_reg(uic_pkg::ADDR_SRC, 8'h09);
      rd_chk("source", uic_pkg::ADDR_SRC, 8'hC1);
      i_host.rd_reg(uic_pkg::ADDR_HOLD, d);
      i_host.wr_reg(uic_pkg::ADDR_HOLD, 8'h5A);
      for (int k = 0; k < 8; k++) begin
         i_host.wr_reg(uic_pkg::ADDR_MASK, msk_tab[k]);
         @(negedge clk);
         case (k)
            0: rx.overrun = 1'b1;
            1: rx.count = 7'h04;
            3: delta = 4'h1;
            4: evt.xoff_det = 1'b1;
            5: cts_n = 1'b1;
            6: rts_n = 1'b1;
            7: evt.wake = 1'b1;
            default: ;
         endcase
         @(negedge clk);
         rx.overrun = 1'b0;
         evt = '0;
         wait_irq(1'b1);
         rd_chk("source", uic_pkg::ADDR_SRC, {2'b11, code_tab[k]});
         if (k == 0) begin
            rd_chk("line", uic_pkg::ADDR_LINE, 8'h62);
            rd_chk("line", uic_pkg::ADDR_LINE, 8'h60);
         end
         if (k == 1) rx.count = 7'h03;
         if (k == 3 || k == 5 || k == 6) begin
            rd_chk("modem", uic_pkg::ADDR_MODEM, ms);
            delta = 4'h0;
         end
         wait_irq(1'b0);
         rd_chk("source", uic_pkg::ADDR_SRC, 8'hC1);
      end
      // Line event arrives while receive ready is presented
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'h05);
      rx.count = 7'h04;
      wait_irq(1'b1);
      rx.overrun = 1'b1;
      @(negedge clk);
      rx.overrun = 1'b0;
      repeat (2) @(negedge clk);
      rd_chk("source", uic_pkg::ADDR_SRC, 8'hC4);
      rx.count = 7'h00;
      repeat (3) @(negedge clk);
      rd_chk("source", uic_pkg::ADDR_SRC, 8'hC6);
      rd_chk("line", uic_pkg::ADDR_LINE, 8'h62);
      wait_irq(1'b0);
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'h01);
      repeat (24) begin
         r = rnd();
         @(negedge clk);
         rx.count = {1'b0, r[5:0]};
         rx_trig = {1'b0, r[11:6]} | 7'h01;
         rx.err_top = r[14:12];
         rx.err_in_fifo = r[15];
         tx_count = r[16] ? 7'h00 : 7'h05;
         sh_empty = r[17];
         repeat (3) @(negedge clk);
         chk("irq", 8'(int'(rx.count) >= int'(rx_trig)), {7'h00, irq});
         rd_chk("line", uic_pkg::ADDR_LINE, {r[15], r[16] & r[17], r[16], r[14:12], 1'b0, rx.count != 7'h00});
      end
      rx.err_top = 3'h0;
      rx.err_in_fifo = 1'b0;
      // Timeout: data below trigger, a tick every cycle, ten-bit characters
      rx.count = 7'h02;
      rx_trig = 7'h04;
      tick = 1'b1;
      repeat (int'(uic_pkg::TMO_CHARS) * 10 + int'(uic_pkg::TMO_EXTRA_BITS) - 1) @(negedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      wait_irq(1'b1);
      tick = 1'b0;
      rd_chk("source", uic_pkg::ADDR_SRC, 8'hCC);
      i_host.rd_reg(uic_pkg::ADDR_HOLD, d);
      wait_irq(1'b0);
      // Polled mode: data waits with every interrupt masked
      i_host.wr_reg(uic_pkg::ADDR_MASK, 8'h00);
      rx.count = 7'h0A;
      rx_trig = 7'h04;
      repeat (3) @(negedge clk);
      chk("irq", 8'h00, {7'h00, irq});
      rd_chk("line", uic_pkg::ADDR_LINE, {1'b0, ~tx_count[0] & sh_empty, ~tx_count[0], 5'h01});
      give_verdict();
   end
endmodule
